// *** mtrr_top.sv ***
// Summary of operation
// - The first-point register shows calibrated X high and Y low and resets to 0x80008000.
// - The first-point register updates in both modes and in single-touch mode holds the one contact.
// - The second-point register packs X high and Y low, resets to no-touch, and updates only in multi-touch mode.
// - The third-point register uses the same layout and reset and updates only in multi-touch mode.
// - The fourth-point register uses the same layout and reset and updates only in multi-touch mode.
// - The fifth point's X and Y sit in two 16-bit registers resetting to 0x8000, updated only in multi-touch mode.
// - The raw register shows uncalibrated X high and Y low and updates only in single-touch mode.
// - The tag register carries the tag in bits 7 to 0, upper bits read zero, and resets to zero.
// - The tag field changes only once per frame, when the frame's last line has gone out.
// - A valid tag is 1 to 255 and zero means no touch is present.
// - The tag register works in both modes and in multi-touch mode belongs to the first point.
// - Mode bit 0 low selects multi-touch and high selects single-touch, resetting to high.
// - A separate tag coordinate register feeds the lookup whose result becomes the first-point tag.
`timescale 1ns/1ps
`default_nettype none
module mtrr_top
  import mtrr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [MTRR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [MTRR_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MTRR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [MTRR_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [4:0] point_present,
  input wire logic [15:0] p1_x,
  input wire logic [15:0] p1_y,
  input wire logic [15:0] p2_x,
  input wire logic [15:0] p2_y,
  input wire logic [15:0] p3_x,
  input wire logic [15:0] p3_y,
  input wire logic [15:0] p4_x,
  input wire logic [15:0] p4_y,
  input wire logic [15:0] p5_x,
  input wire logic [15:0] p5_y,
  input wire logic [15:0] raw_x,
  input wire logic [15:0] raw_y,
  input wire logic [15:0] tag_x,
  input wire logic [15:0] tag_y,
  input wire logic frame_done,
  input wire logic [7:0] tag_lookup,
  output logic detection_mode,
  output logic [31:0] tag_query_xy
);

  // register state
  logic mode_q;
  logic [31:0] p1_xy_q;
  logic [31:0] p2_xy_q;
  logic [31:0] p3_xy_q;
  logic [31:0] p4_xy_q;
  logic [15:0] p5_x_q;
  logic [15:0] p5_y_q;
  logic [31:0] raw_xy_q;
  logic [31:0] tag_xy_q;
  logic [7:0] tag_q;
  logic touched_q;

  // bus side
  logic wr_en;
  logic [MTRR_ADDR_W-1:0] wr_addr;
  logic [MTRR_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [MTRR_ADDR_W-1:0] rd_addr;
  logic [MTRR_DATA_W-1:0] rd_data;
  logic rd_err;

  // packs a point into the X-high, Y-low word
  function automatic logic [31:0] mtrr_pack(input logic [15:0] x,
                                            input logic [15:0] y);
    logic [31:0] w;
    w = '0;
    w[MTRR_X_LSB +: 16] = x;
    w[MTRR_Y_LSB +: 16] = y;
    return w;
  endfunction : mtrr_pack

  // true when an address hits a mapped register
  function automatic logic mtrr_mapped(input logic [MTRR_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      MTRR_OFS_MODE, MTRR_OFS_RAW, MTRR_OFS_P2_XY, MTRR_OFS_P5_Y,
      MTRR_OFS_P1_XY, MTRR_OFS_TAG_XY, MTRR_OFS_TAG, MTRR_OFS_P5_X,
      MTRR_OFS_P3_XY, MTRR_OFS_P4_XY: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : mtrr_mapped

  mtrr_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // unmapped addresses answer with slave error
  assign wr_err = !mtrr_mapped(wr_addr);
  assign rd_err = !mtrr_mapped(rd_addr);

  // detection mode control, only writable field in the block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MTRR_RST_MODE;
    end else if (wr_en && wr_addr == MTRR_OFS_MODE && wr_strb[0]) begin
      mode_q <= wr_data[MTRR_MODE_BIT];
    end
  end

  // first point tracks the contact in either mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_xy_q <= MTRR_RST_XY;
    end else if (sample_valid) begin
      p1_xy_q <= point_present[0] ? mtrr_pack(p1_x, p1_y)
                                  : MTRR_RST_XY;
    end
  end

  // points two to five move only in multi-touch mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p2_xy_q <= MTRR_RST_XY;
      p3_xy_q <= MTRR_RST_XY;
      p4_xy_q <= MTRR_RST_XY;
      p5_x_q <= MTRR_RST_HALF;
      p5_y_q <= MTRR_RST_HALF;
    end else if (sample_valid && mode_q == MTRR_MODE_MULTI) begin
      p2_xy_q <= point_present[1] ? mtrr_pack(p2_x, p2_y)
                                  : MTRR_RST_XY;
      p3_xy_q <= point_present[2] ? mtrr_pack(p3_x, p3_y)
                                  : MTRR_RST_XY;
      p4_xy_q <= point_present[3] ? mtrr_pack(p4_x, p4_y)
                                  : MTRR_RST_XY;
      p5_x_q <= point_present[4] ? p5_x : MTRR_RST_HALF;
      p5_y_q <= point_present[4] ? p5_y : MTRR_RST_HALF;
    end
  end

  // raw coordinate moves only in single-touch mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_xy_q <= MTRR_RST_RAW;
    end else if (sample_valid && mode_q == MTRR_MODE_COMPAT) begin
      raw_xy_q <= mtrr_pack(raw_x, raw_y);
    end
  end

  // tag coordinate of the first point, steers the lookup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_xy_q <= MTRR_RST_TAG_XY;
      touched_q <= 1'b0;
    end else if (sample_valid) begin
      tag_xy_q <= point_present[0] ? mtrr_pack(tag_x, tag_y)
                                   : MTRR_RST_TAG_XY;
      touched_q <= point_present[0];
    end
  end

  // tag result committed once per frame end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_q <= MTRR_RST_TAG;
    end else if (frame_done) begin
      tag_q <= touched_q ? tag_lookup : MTRR_TAG_NONE;
    end
  end

  // outputs toward the touch engine and the tag lookup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detection_mode <= MTRR_RST_MODE;
      tag_query_xy <= MTRR_RST_TAG_XY;
    end else begin
      detection_mode <= mode_q;
      tag_query_xy <= tag_xy_q;
    end
  end

  // read mux, reserved bits zero; result registers have no write path
  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      MTRR_OFS_MODE: rd_data[MTRR_MODE_BIT] = mode_q;
      MTRR_OFS_RAW: rd_data = raw_xy_q;
      MTRR_OFS_P2_XY: rd_data = p2_xy_q;
      MTRR_OFS_P5_Y: rd_data[15:0] = p5_y_q;
      MTRR_OFS_P1_XY: rd_data = p1_xy_q;
      MTRR_OFS_TAG_XY: rd_data = tag_xy_q;
      MTRR_OFS_TAG: rd_data[MTRR_TAG_W-1:0] = tag_q;
      MTRR_OFS_P5_X: rd_data[15:0] = p5_x_q;
      MTRR_OFS_P3_XY: rd_data = p3_xy_q;
      MTRR_OFS_P4_XY: rd_data = p4_xy_q;
      default: rd_data = '0;
    endcase
  end

endmodule : mtrr_top
`default_nettype wire

// *** mtrr_pkg.sv ***
package mtrr_pkg;

  // bus geometry
  localparam int unsigned MTRR_ADDR_W = 12;
  localparam int unsigned MTRR_DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] MTRR_OFS_MODE = 12'h108;
  localparam logic [11:0] MTRR_OFS_RAW = 12'h110;
  localparam logic [11:0] MTRR_OFS_P2_XY = 12'h11c;
  localparam logic [11:0] MTRR_OFS_P5_Y = 12'h120;
  localparam logic [11:0] MTRR_OFS_P1_XY = 12'h124;
  localparam logic [11:0] MTRR_OFS_TAG_XY = 12'h128;
  localparam logic [11:0] MTRR_OFS_TAG = 12'h12c;
  localparam logic [11:0] MTRR_OFS_P5_X = 12'h16c;
  localparam logic [11:0] MTRR_OFS_P3_XY = 12'h18c;
  localparam logic [11:0] MTRR_OFS_P4_XY = 12'h190;

  // field positions
  localparam int unsigned MTRR_X_LSB = 16;
  localparam int unsigned MTRR_Y_LSB = 0;
  localparam int unsigned MTRR_MODE_BIT = 0;
  localparam int unsigned MTRR_TAG_W = 8;

  // reset values
  localparam logic [31:0] MTRR_RST_XY = 32'h80008000;
  localparam logic [15:0] MTRR_RST_HALF = 16'h8000;
  localparam logic [31:0] MTRR_RST_RAW = 32'h0fffffff;
  localparam logic [31:0] MTRR_RST_TAG_XY = 32'h80008000;
  localparam logic [7:0] MTRR_RST_TAG = 8'h00;
  localparam logic MTRR_RST_MODE = 1'b1;

  // detection mode encodings
  localparam logic MTRR_MODE_MULTI = 1'b0;
  localparam logic MTRR_MODE_COMPAT = 1'b1;

  // tag meaning no touch
  localparam logic [7:0] MTRR_TAG_NONE = 8'h00;

  // bus responses
  localparam logic [1:0] MTRR_RESP_OKAY = 2'b00;
  localparam logic [1:0] MTRR_RESP_SLVERR = 2'b10;

endpackage : mtrr_pkg

// *** mtrr_axil_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtrr_axil_slave
  import mtrr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [MTRR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [MTRR_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MTRR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [MTRR_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [MTRR_ADDR_W-1:0] wr_addr,
  output logic [MTRR_DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [MTRR_ADDR_W-1:0] rd_addr,
  input wire logic [MTRR_DATA_W-1:0] rd_data,
  input wire logic rd_err
);

  logic aw_have_q;
  logic w_have_q;
  logic [MTRR_ADDR_W-1:0] awaddr_q;
  logic [MTRR_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic wr_go;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  // commit once both halves are held and no response is pending
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  assign wr_en = wr_go;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = s_axi_araddr;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_wready <= 1'b1;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MTRR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? MTRR_RESP_SLVERR : MTRR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= MTRR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? MTRR_RESP_SLVERR : MTRR_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : mtrr_axil_slave
`default_nettype wire

// *** mtrr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mtrr_checker
  import mtrr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [MTRR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [MTRR_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [4:0] point_present,
  input wire logic [15:0] tag_x,
  input wire logic [15:0] tag_y,
  input wire logic detection_mode,
  input wire logic [31:0] tag_query_xy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // read address accepted on this edge
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // bus answers and holds
  rd_answer_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed while stalled");
  wr_answer_a: assert property (w_hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  unmapped_rd_a: assert property (ar_hs && s_axi_araddr == 12'h000 |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused with zero data");

  // reserved bits of narrow registers
  tag_resv_a: assert property (ar_hs && s_axi_araddr == 12'h12c |=>
    s_axi_rdata[31:8] == 24'h0)
    else $error("tag upper bits not zero");
  half_resv_a: assert property (ar_hs && (s_axi_araddr == 12'h120 ||
    s_axi_araddr == 12'h16c) |=> s_axi_rdata[31:16] == 16'h0)
    else $error("half register upper bits not zero");
  mode_resv_a: assert property (ar_hs && s_axi_araddr == 12'h108 |=>
    s_axi_rdata[31:1] == 31'h0)
    else $error("mode register upper bits not zero");

  // mode and tag coordinate outputs
  mode_reset_a: assert property ($rose(aresetn) |-> detection_mode)
    else $error("mode not single touch after reset");
  tag_query_a: assert property (sample_valid && point_present[0]
    |-> ##2 tag_query_xy == {$past(tag_x, 2), $past(tag_y, 2)})
    else $error("tag coordinate not forwarded");
  // without a first point the coordinate falls back to its idle pattern
  tag_idle_a: assert property (sample_valid && !point_present[0]
    |-> ##2 tag_query_xy == MTRR_RST_TAG_XY)
    else $error("tag coordinate not idle without first point");
endmodule : mtrr_checker
`default_nettype wire

// *** tb_multi_touch_result_registers.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_multi_touch_result_registers
  import mtrr_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, detection_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, tag_query_xy, d;
  logic sample_valid = 1'b0, frame_done = 1'b0;
  logic [4:0] point_present = 5'h00;
  logic [15:0] px [5] = '{default: 16'h0};
  logic [15:0] py [5] = '{default: 16'h0};
  logic [15:0] raw_x = 16'h0, raw_y = 16'h0, tag_x = 16'h0, tag_y = 16'h0;
  logic [7:0] tag_lookup = 8'h00;
  int n_mismatch = 0;
  int comparisons = 0;
  // reset value rows: address beside expected word
  logic [43:0] rows [10] = '{{12'h108, 32'h1}, {12'h110, 32'h0fffffff},
    {12'h11c, 32'h80008000}, {12'h124, 32'h80008000},
    {12'h18c, 32'h80008000}, {12'h190, 32'h80008000},
    {12'h120, 32'h00008000}, {12'h16c, 32'h00008000},
    {12'h128, 32'h80008000}, {12'h12c, 32'h0}};

  mtrr_top i_dut (
    .*,
    .p1_x(px[0]), .p1_y(py[0]), .p2_x(px[1]), .p2_y(py[1]),
    .p3_x(px[2]), .p3_y(py[2]), .p4_x(px[3]), .p4_y(py[3]),
    .p5_x(px[4]), .p5_y(py[4])
  );

  // 100 MHz clock
  always #5 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // read with one stalled cycle before rready
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk({30'h0, r}, 32'h0);
  endtask : rc

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // one touch sample, point i at (k+i, k+0x100+i)
  task automatic smp(input logic [4:0] m, input logic [15:0] k);
    point_present <= m;
    sample_valid <= 1'b1;
    raw_x <= k ^ 16'h0f0f;
    raw_y <= ~k;
    tag_x <= k + 16'h0020;
    tag_y <= k + 16'h0021;
    for (int i = 0; i < 5; i++) begin
      px[i] <= k + 16'(i);
      py[i] <= k + 16'h0100 + 16'(i);
    end
    @(posedge aclk);
    sample_valid <= 1'b0;
    @(posedge aclk);
  endtask : smp

  task automatic frm(input logic [7:0] t);
    tag_lookup <= t;
    frame_done <= 1'b1;
    @(posedge aclk);
    frame_done <= 1'b0;
    @(posedge aclk);
  endtask : frm

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run of about 130 cycles
  initial begin
    repeat (4000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) rc(rows[i][43:32], rows[i][31:0]);
    $display("reset values done");
    smp(5'h1f, 16'h1234);
    rc(12'h124, 32'h12341334);
    rc(12'h110, 32'h1d3bedcb);
    rc(12'h11c, 32'h80008000);
    rc(12'h18c, 32'h80008000);
    rc(12'h190, 32'h80008000);
    rc(12'h16c, 32'h00008000);
    $display("single touch done");
    wr(12'h108, 32'h0);
    chk({30'h0, r}, 32'h0);
    @(posedge aclk);
    chk({31'h0, detection_mode}, 32'h0);
    smp(5'h1b, 16'h4000);
    rc(12'h11c, 32'h40014101);
    rc(12'h18c, 32'h80008000);
    rc(12'h190, 32'h40034103);
    rc(12'h16c, 32'h00004004);
    rc(12'h120, 32'h00004104);
    rc(12'h110, 32'h1d3bedcb);
    rc(12'h124, 32'h40004100);
    $display("multi touch done");
    rc(12'h12c, 32'h0);
    frm(8'hff);
    rc(12'h12c, 32'h000000ff);
    rc(12'h128, 32'h40204021);
    chk(tag_query_xy, 32'h40204021);
    smp(5'h1e, 16'h0777);
    rc(12'h12c, 32'h000000ff);
    rc(12'h124, 32'h80008000);
    frm(8'h05);
    rc(12'h12c, 32'h0);
    $display("tag done");
    wr(12'h124, 32'h12345678);
    chk({30'h0, r}, 32'h0);
    rc(12'h124, 32'h80008000);
    wr(12'h12c, 32'hffffffff);
    rc(12'h12c, 32'h0);
    rd(12'h000);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    $display("write ignore done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(12'h108, 32'h1);
    rc(12'h11c, 32'h80008000);
    $display("second reset done");
    conclude();
  end
endmodule : tb_multi_touch_result_registers

bind mtrr_top mtrr_checker i_chk (.*);
`default_nettype wire
